// >>> shared/hpmc_pkg.sv
// package: csr addresses, field positions, reset values and types of the performance counters
package hpmc_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int COUNT_WIDTH  = 64;
  localparam int HALF_WIDTH   = 32;
  localparam int EVENT_COUNT  = 16;
  localparam int EVENT_MAX    = 29;
  localparam int EVENT_FIRST  = 3;
  // ----------------------------------------------------------------
  // csr addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_COUNTER_INHIBIT = 12'h320;
  localparam logic [11:0] ADDR_EVENT_SELECT    = 12'h320; // plus index 3..31
  localparam logic [11:0] ADDR_CYCLE_LOW       = 12'hb00;
  localparam logic [11:0] ADDR_RETIRED_LOW     = 12'hb02;
  localparam logic [11:0] ADDR_EVENT_LOW       = 12'hb00; // plus index
  localparam logic [11:0] ADDR_CYCLE_HIGH      = 12'hb80;
  localparam logic [11:0] ADDR_RETIRED_HIGH    = 12'hb82;
  localparam logic [11:0] ADDR_EVENT_HIGH      = 12'hb80; // plus index
  localparam logic [11:0] ADDR_USER_LOW        = 12'hc00;
  localparam logic [11:0] ADDR_USER_HIGH       = 12'hc80;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int INHIBIT_CYCLE_BIT   = 0;
  localparam int INHIBIT_RETIRED_BIT = 2;
  localparam int SEL_CYCLES          = 0;
  localparam int SEL_RETIRED         = 1;
  localparam logic [31:0] INHIBIT_RESET = 32'hffff_ffff;
  localparam logic [63:0] COUNT_RESET   = 64'h0;
  localparam logic [15:0] SELECT_RESET  = 16'h0;
  // ----------------------------------------------------------------
  // csr operation codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HPMC_OP_WRITE = 2'h1,
    HPMC_OP_SET   = 2'h2,
    HPMC_OP_CLEAR = 2'h3
  } hpmc_op_type;
endpackage

// >>> shared/hpmc_count_if.sv
// interface: shared control between the csr front end and one counter slot
`timescale 1ns/100ps
`default_nettype none
interface hpmc_count_if;
  logic        write_low;  // load lower half
  logic        write_high; // load upper half
  logic [31:0] write_data; // value for the half
  logic        enable;     // count this cycle
  logic [63:0] value;      // current count
  modport front (output write_low, output write_high, output write_data, output enable,
                 input value);
  modport slot  (input write_low, input write_high, input write_data, input enable,
                 output value);
endinterface
`default_nettype wire

// >>> verilog/hpmc_counter.sv
// one 64-bit counter with independent half loads
`timescale 1ns/100ps
`default_nettype none
module hpmc_counter (
  input  wire logic   clock,
  input  wire logic   rst_n,
  hpmc_count_if.slot  port
);
  import hpmc_pkg::*;
  logic [63:0] count;
  wire  [63:0] next_count;
  // ----------------------------------------------------------------
  // increment with carry into the upper half, half loads
  // ----------------------------------------------------------------
  wire [63:0] incremented = count + 64'h1;
  assign next_count = port.write_low  ? {count[63:32], port.write_data} :
                      port.write_high ? {port.write_data, count[31:0]}  :
                      port.enable     ? incremented : count;
  // storage on the gated core clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= COUNT_RESET;
    end else begin
      count <= next_count;
    end
  end
  assign port.value = count;
endmodule // hpmc_counter
`default_nettype wire

// >>> verilog/hpmc_top.sv
// top of the hardware performance counters: csr decode, selectors, inhibit, counter slots
`timescale 1ns/100ps
`default_nettype none
// How it works
// - cycle, retired and event counters are all 64 bits wide.
// - event counter quantity is a parameter, 0 to 29, default 1.
// - event counters use indices 3 to 31, each with same-index selector.
// - cycle and retired counters exist whatever the parameter says.
// - any unimplemented counter index reads zero.
// - every counter runs on the gated core clock, so sleep pauses it.
// - selector bits 0 to 10 pick cycles through compressed retirement events.
// - selector bits 11 to 15 pick stall and auxiliary unit events.
// - a set selector bit counts the event with that bit's id.
// - a zero selector makes its counter count nothing.
// - after reset every counter is inhibited and does not advance.
// - inhibit register at 0x320: bit 0 cycle, bit 2 retired, bit x event x.
// - lower 32 bits through base register, upper 32 through high register.
// - reading any counter register never changes it.
// - registers reached only by csr write and set/clear instructions.
// - each event counter adds 64 count, 16 selector, one inhibit bit.
module hpmc_top #(
  parameter int event_counter_quantity = 1
) (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                csr_access,
  input  wire hpmc_pkg::hpmc_op_type csr_op,
  input  wire logic [11:0]         csr_addr,
  input  wire logic [31:0]         csr_wdata,
  output logic [31:0]              csr_rdata,
  output logic                     csr_hit,
  input  wire logic                retired_event,
  input  wire logic                load_use_hazard_event,
  input  wire logic                jump_register_hazard_event,
  input  wire logic                fetch_wait_event,
  input  wire logic                load_event,
  input  wire logic                store_event,
  input  wire logic                jump_event,
  input  wire logic                branch_event,
  input  wire logic                taken_branch_event,
  input  wire logic                compressed_retire_event,
  input  wire logic                pipe_stall_event,
  input  wire logic                aux_unit_type_conflict_event,
  input  wire logic                aux_unit_contention_event,
  input  wire logic                aux_unit_dependency_event,
  input  wire logic                aux_unit_writeback_event
);
  import hpmc_pkg::*;
  localparam int N = event_counter_quantity;
  localparam int SLOTS = N + 2;
  // ----------------------------------------------------------------
  // event vector, bit position is event id
  // ----------------------------------------------------------------
  wire [EVENT_COUNT-1:0] events = {
    aux_unit_writeback_event, aux_unit_dependency_event, aux_unit_contention_event,
    aux_unit_type_conflict_event, pipe_stall_event, compressed_retire_event,
    taken_branch_event, branch_event, jump_event, store_event, load_event,
    fetch_wait_event, jump_register_hazard_event, load_use_hazard_event,
    retired_event, 1'b1};
  // ----------------------------------------------------------------
  // inhibit register, one bit per implemented counter
  // ----------------------------------------------------------------
  logic [31:0] counter_inhibit;
  wire  [31:0] inhibit_mask;
  wire  [31:0] next_inhibit;
  // ----------------------------------------------------------------
  // csr decode
  // ----------------------------------------------------------------
  wire        is_inhibit   = csr_addr == ADDR_COUNTER_INHIBIT;
  wire [11:0] sel_offset   = csr_addr - ADDR_EVENT_SELECT;
  wire [11:0] low_offset   = csr_addr - ADDR_EVENT_LOW;
  wire [11:0] high_offset  = csr_addr - ADDR_EVENT_HIGH;
  wire [11:0] ulow_offset  = csr_addr - ADDR_USER_LOW;
  wire [11:0] uhigh_offset = csr_addr - ADDR_USER_HIGH;
  wire        in_select    = sel_offset  >= 12'h3 && sel_offset <= 12'h1f;
  wire        in_low       = low_offset  <= 12'h1f && low_offset != 12'h1;
  wire        in_high      = high_offset <= 12'h1f && high_offset != 12'h1;
  wire        in_ulow      = ulow_offset <= 12'h1f && ulow_offset != 12'h1;
  wire        in_uhigh     = uhigh_offset <= 12'h1f && uhigh_offset != 12'h1;
  wire [4:0]  index        = in_select ? sel_offset[4:0] : in_low ? low_offset[4:0] :
                             in_high ? high_offset[4:0] : in_ulow ? ulow_offset[4:0] :
                             uhigh_offset[4:0];
  wire        read_high    = in_high || in_uhigh;
  wire        writable     = csr_access && (is_inhibit || in_select || in_low || in_high);
  // ----------------------------------------------------------------
  // read-modify-write value for set and clear forms
  // ----------------------------------------------------------------
  logic [31:0] old_value;
  wire  [31:0] new_value = (csr_op == HPMC_OP_SET)   ? (old_value | csr_wdata) :
                           (csr_op == HPMC_OP_CLEAR) ? (old_value & ~csr_wdata) :
                           csr_wdata;
  // ----------------------------------------------------------------
  // per-slot storage: slot 0 cycle, slot 1 retired, slot 2+k event 3+k
  // ----------------------------------------------------------------
  wire [63:0] slot_value  [SLOTS];
  wire [4:0]  slot_index  [SLOTS];
  wire [SLOTS-1:0] slot_hit;
  wire [15:0] select_value [SLOTS];
  assign slot_index[0] = 5'h0;
  assign slot_index[1] = 5'h2;
  assign select_value[0] = 16'h0;
  assign select_value[1] = 16'h0;
  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_slot
      hpmc_count_if link ();
      wire hit = index == slot_index[g];
      wire event_on;
      if (g >= 2) begin : g_event
        logic [15:0] event_select;
        assign slot_index[g] = 5'(g + 1);
        assign select_value[g] = event_select;
        // selector write, bit 15 kept as the top of the 16 events
        always_ff @(posedge clock or negedge rst_n) begin
          if (!rst_n) begin
            event_select <= SELECT_RESET;
          end else if (writable && in_select && hit) begin
            event_select <= new_value[15:0];
          end
        end
        assign event_on = |(event_select & events);
      end else if (g == 0) begin : g_cycle
        assign event_on = events[SEL_CYCLES];
      end else begin : g_retired
        assign event_on = events[SEL_RETIRED];
      end
      assign slot_hit[g]     = hit;
      assign link.enable     = event_on && !counter_inhibit[slot_index[g]];
      assign link.write_low  = writable && in_low && hit;
      assign link.write_high = writable && in_high && hit;
      assign link.write_data = new_value;
      assign slot_value[g]   = link.value;
      hpmc_counter u_counter (
        .clock (clock),
        .rst_n (rst_n),
        .port  (link)
      );
    end
  endgenerate
  // ----------------------------------------------------------------
  // implemented inhibit bits; others stay zero on read
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < 32; g++) begin : g_mask
      if (g == INHIBIT_CYCLE_BIT || g == INHIBIT_RETIRED_BIT ||
          (g >= EVENT_FIRST && g < EVENT_FIRST + N)) begin : g_on
        assign inhibit_mask[g] = 1'b1;
      end else begin : g_off
        assign inhibit_mask[g] = 1'b0;
      end
    end
  endgenerate
  assign next_inhibit = (writable && is_inhibit) ? (new_value & inhibit_mask) :
                        counter_inhibit;
  // inhibit register, all counters stopped after reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      counter_inhibit <= INHIBIT_RESET;
    end else begin
      counter_inhibit <= next_inhibit | ~inhibit_mask;
    end
  end
  // ----------------------------------------------------------------
  // read mux, unimplemented indices give zero
  // ----------------------------------------------------------------
  always_comb begin
    old_value = 32'h0;
    if (is_inhibit) begin
      old_value = counter_inhibit & inhibit_mask;
    end
    for (int s = 0; s < SLOTS; s++) begin
      if (slot_hit[s] && in_select) begin
        old_value = {16'h0, select_value[s]};
      end else if (slot_hit[s] && (in_low || in_high || in_ulow || in_uhigh)) begin
        old_value = read_high ? slot_value[s][63:32] : slot_value[s][31:0];
      end
    end
  end
  assign csr_hit   = csr_access && (is_inhibit || in_select || in_low || in_high ||
                                    in_ulow || in_uhigh);
  assign csr_rdata = old_value;
endmodule // hpmc_top
`default_nettype wire

// >>> tb/hpmc_asserts.sv
// checker: port-level properties of the performance counter top
`timescale 1ns/100ps
`default_nettype none
module hpmc_asserts import hpmc_pkg::*; #(
  parameter int event_counter_quantity = 1
) (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        csr_access,
  input wire hpmc_op_type csr_op,
  input wire logic [11:0] csr_addr,
  input wire logic [31:0] csr_wdata,
  input wire logic [31:0] csr_rdata,
  input wire logic        retired_event
);
  logic inh_seen;
  // decoded access kinds
  wire inh_acc  = csr_access && csr_addr == 12'h320;
  wire idle_cyc = !csr_access && csr_addr == 12'hb00;
  wire idle_ret = !csr_access && csr_addr == 12'hb02;
  wire unimpl   = csr_addr[11:5] inside {7'h58, 7'h5c}
                  && csr_addr[4:0] > 5'(2 + event_counter_quantity);
  // set once software has touched the inhibit register
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n) inh_seen <= 1'b0;
    else if (inh_acc) inh_seen <= 1'b1;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  inhibit_reset_a: assert property (!inh_seen && csr_addr == 12'h320 |-> csr_rdata[2:0] == 3'h5)
    else $error("inhibit not set after reset");
  inhibit_write_a: assert property (inh_acc && csr_op == HPMC_OP_WRITE ##1 csr_addr == 12'h320
    |-> csr_rdata[3:0] == ($past(csr_wdata[3:0]) & 4'hd)) else $error("inhibit write lost");
  inhibit_set_a: assert property (inh_acc && csr_op == HPMC_OP_SET ##1 csr_addr == 12'h320
    |-> (csr_rdata[3:0] & $past(csr_wdata[3:0])) == ($past(csr_wdata[3:0]) & 4'hd))
    else $error("inhibit set lost");
  inhibit_clear_a: assert property (inh_acc && csr_op == HPMC_OP_CLEAR ##1 csr_addr == 12'h320
    |-> (csr_rdata[3:0] & $past(csr_wdata[3:0])) == 4'h0) else $error("inhibit clear lost");
  unimpl_zero_a: assert property (unimpl |-> csr_rdata == 32'h0)
    else $error("unimplemented counter not zero");
  select_width_a: assert property (csr_addr == 12'h323 |-> csr_rdata[31:16] == 16'h0)
    else $error("selector upper bits set");
  cycle_step_a: assert property (idle_cyc && $past(idle_cyc) |-> csr_rdata - $past(csr_rdata) <= 32'h1)
    else $error("cycle count jumped");
  retired_hold_a: assert property (idle_ret && $past(idle_ret) && !$past(retired_event)
    |-> $stable(csr_rdata)) else $error("retired count moved without event");
endmodule // hpmc_asserts
bind hpmc_top hpmc_asserts #(.event_counter_quantity(event_counter_quantity)) i_asserts (
  .clock, .rst_n, .csr_access, .csr_op, .csr_addr, .csr_wdata, .csr_rdata, .retired_event);
`default_nettype wire

// >>> tb/hpmc_core_model.sv
// partner: pipeline model raising event strobes in timed bursts
`timescale 1ns/100ps
`default_nettype none
module hpmc_core_model (
  input  wire logic   clock,
  output logic [15:1] ev
);
  initial ev = '0;
  // strobes change on the falling edge and fall idle after n cycles
  task automatic burst(input logic [15:1] m, input int n);
    @(negedge clock);
    ev = m;
    repeat (n) @(negedge clock);
    ev = '0;
  endtask
endmodule // hpmc_core_model
`default_nettype wire

// >>> tb/hpmc_top_tb.sv
// testbench: csr accesses and event bursts into the performance counter top
`timescale 1ns/100ps
`default_nettype none
module hpmc_top_tb;
  import hpmc_pkg::*;
  logic        clock = 0, rst_n = 0, csr_access = 0, csr_hit;
  hpmc_op_type csr_op = HPMC_OP_WRITE;
  logic [11:0] csr_addr = '0;
  logic [31:0] csr_wdata = '0, csr_rdata;
  logic [15:1] ev;
  int          error_cnt = 0, checks_done = 0;
  hpmc_core_model i_core (.clock(clock), .ev(ev));
  hpmc_top #(.event_counter_quantity(1)) i_dut (.clock(clock), .rst_n(rst_n),
    .csr_access(csr_access), .csr_op(csr_op), .csr_addr(csr_addr), .csr_wdata(csr_wdata),
    .csr_rdata(csr_rdata), .csr_hit(csr_hit), .retired_event(ev[1]),
    .load_use_hazard_event(ev[2]), .jump_register_hazard_event(ev[3]),
    .fetch_wait_event(ev[4]), .load_event(ev[5]), .store_event(ev[6]), .jump_event(ev[7]),
    .branch_event(ev[8]), .taken_branch_event(ev[9]), .compressed_retire_event(ev[10]),
    .pipe_stall_event(ev[11]), .aux_unit_type_conflict_event(ev[12]),
    .aux_unit_contention_event(ev[13]), .aux_unit_dependency_event(ev[14]),
    .aux_unit_writeback_event(ev[15]));
  // compare, access and closing tasks
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input hpmc_op_type op = HPMC_OP_WRITE);
    @(negedge clock);
    csr_access = 1'b1;
    csr_op     = op;
    csr_addr   = a;
    csr_wdata  = d;
    @(negedge clock);
    csr_access = 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(negedge clock);
    csr_addr = a;
    #1 chk($sformatf("csr %h", a), csr_rdata, exp);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // everything stopped and cleared after reset
  task automatic t_reset;
    rd(12'h320, 32'hd);
    rd(12'hb00, 32'h0);
    repeat (4) @(posedge clock);
    rd(12'hb00, 32'h0);
    rd(12'hb82, 32'h0);
    rd(12'h323, 32'h0);
    $display("reset test done");
  endtask
  // every selector code, zero selector and inhibit set/clear
  task automatic t_events;
    wr(12'h320, 32'h0);
    wr(12'h323, 32'h1);
    wr(12'hb03, 32'h0);
    rd(12'hb03, 32'h1);
    for (int i = 1; i < 16; i++) begin
      wr(12'h323, 32'h1 << i);
      wr(12'hb03, 32'h0);
      i_core.burst(15'h1 << (i - 1), 3);
      rd(12'hb03, 32'h3);
    end
    wr(12'h323, 32'h0);
    i_core.burst('1, 3);
    rd(12'hb03, 32'h3);
    wr(12'h323, 32'h2);
    wr(12'h320, 32'h8, HPMC_OP_SET);
    rd(12'h320, 32'h8);
    i_core.burst('1, 3);
    rd(12'hb03, 32'h3);
    wr(12'h320, 32'h8, HPMC_OP_CLEAR);
    i_core.burst('1, 2);
    rd(12'hb03, 32'h5);
    rd(12'hb02, 32'hb);
    rd(12'hb02, 32'hb);
    $display("event test done");
  endtask
  // half loads, carry and unimplemented indices
  task automatic t_limits;
    wr(12'h320, 32'h1);
    wr(12'hb00, 32'h10);
    wr(12'hb80, 32'h7);
    rd(12'hb00, 32'h10);
    rd(12'hb80, 32'h7);
    wr(12'hb03, 32'hffff_ffff);
    wr(12'hb83, 32'h0);
    i_core.burst(15'h1, 1);
    rd(12'hb03, 32'h0);
    rd(12'hb83, 32'h1);
    // set and clear forms on a counter half, counter idle meanwhile
    wr(12'hb83, 32'h6, HPMC_OP_SET);
    rd(12'hb83, 32'h7);
    wr(12'hb83, 32'h3, HPMC_OP_CLEAR);
    rd(12'hb83, 32'h4);
    wr(12'hb04, 32'h5);
    rd(12'hb04, 32'h0);
    rd(12'hb84, 32'h0);
    rd(12'h324, 32'h0);
    // address claim outside and inside the block, mirror write refused
    @(negedge clock);
    csr_access = 1'b1;
    csr_addr   = 12'h340;
    #1 chk("hit 340", csr_hit, 32'h0);
    @(negedge clock);
    csr_addr   = 12'hc02;
    #1 chk("hit c02", csr_hit, 32'h1);
    @(negedge clock);
    csr_access = 1'b0;
    rd(12'hc02, 32'hc);
    rd(12'hc83, 32'h4);
    $display("limit test done");
  endtask
  // clock, main sequence and hang guard
  initial forever #5 clock = ~clock;
  initial begin
    repeat (2) @(posedge clock);
    @(negedge clock);
    rst_n = 1;
    t_reset;
    t_events;
    t_limits;
    finish_test;
  end
  initial begin
    #100000;
    error_cnt++;
    finish_test;
  end
endmodule // hpmc_top_tb
`default_nettype wire
